// File: testbench/spm_core_model.sv
// Core side model: plain transfers and interrupt acknowledges
`timescale 1ns/10ps
module spm_core_model (
  input  wire       pclk,
  input  wire       bus_error_signal,
  output reg        bus_cycle_active = 1'b0,
  output reg        bus_cycle_external = 1'b0,
  output reg        data_size_acknowledge = 1'b0,
  output reg        interrupt_acknowledge_cycle = 1'b0,
  output reg  [2:0] ack_level = 3'h0,
  output reg        ack_arb_done = 1'b0,
  output reg        ack_arb_seen = 1'b0
);
  integer err_at;
  // Ack after ack_at edges, none if negative; a bus error ends the cycle a few edges later
  task xfer(input integer ack_at, input integer len, input reg ext);
    integer i;
    integer tail;
    begin
      err_at = -1;
      tail = 4;
      bus_cycle_active <= 1'b1;
      bus_cycle_external <= ext;
      for (i = 0; i < len && tail > 0; i = i + 1)
      begin
        data_size_acknowledge <= (i == ack_at);
        @(posedge pclk);
        if (err_at >= 0)
          tail = tail - 1;
        else if (bus_error_signal === 1'b1)
          err_at = i;
        if (i == ack_at)
          tail = 0;
      end
      bus_cycle_active <= 1'b0;
      data_size_acknowledge <= 1'b0;
      bus_cycle_external <= ~ext;
      @(posedge pclk);
    end
  endtask
  // Acknowledge of one level; seen says another module arbitrated
  task int_ack(input reg [2:0] lvl, input reg seen);
    integer i;
    begin
      err_at = -1;
      bus_cycle_active <= 1'b1;
      interrupt_acknowledge_cycle <= 1'b1;
      ack_level <= lvl;
      for (i = 0; i < 6; i = i + 1)
      begin
        ack_arb_done <= (i == 2);
        ack_arb_seen <= seen && i >= 2;
        @(posedge pclk);
        if (err_at < 0 && bus_error_signal === 1'b1)
          err_at = i;
      end
      bus_cycle_active <= 1'b0;
      interrupt_acknowledge_cycle <= 1'b0;
      ack_arb_seen <= 1'b0;
      ack_level <= ~lvl;
      @(posedge pclk);
    end
  endtask
endmodule

// File: testbench/spm_top_asserts.sv
// Concurrent checks on the protection monitor ports
`timescale 1ns/10ps
module spm_top_asserts (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [23:0] paddr,
  input wire [31:0] pwdata,
  input wire [2:0]  function_code,
  input wire [31:0] prdata,
  input wire        pslverr,
  input wire        freeze,
  input wire        bus_cycle_active,
  input wire        bus_cycle_external,
  input wire        data_size_acknowledge,
  input wire        device_is_master,
  input wire        cpu_halt,
  input wire        interrupt_acknowledge_cycle,
  input wire        ack_arb_done,
  input wire        ack_arb_seen,
  input wire        bus_error_signal,
  input wire        bus_error_pin_out,
  input wire        bus_error_pin_oe,
  input wire        sys_reset_req,
  input wire        pit_irq_req,
  input wire [2:0]  pit_irq_level
);
  reg  [7:0] prot;
  reg  [6:0] wait_cnt;
  wire       acc = psel & penable;
  wire       prot_hit = acc && paddr[19:0] == 20'hffa80;
  // Shadow of the protection control word from accepted writes
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      prot <= 8'h08;
    else if (prot_hit && pwrite && function_code == 3'b101)
      prot <= pwdata[7:0];
  // Unanswered watched cycles; freeze clears it because it may mask the monitor
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      wait_cnt <= 7'h00;
    else if (!bus_cycle_active || data_size_acknowledge || freeze || (bus_cycle_external && !prot[2]))
      wait_cnt <= 7'h00;
    else if (wait_cnt != 7'h7f)
      wait_cnt <= wait_cnt + 7'h01;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_denied;
    prot_hit && function_code != 3'b101;
  endsequence
  sequence s_spurious;
    bus_cycle_active && interrupt_acknowledge_cycle && ack_arb_done && !ack_arb_seen && !pit_irq_req;
  endsequence
  property p_pin_oe;
    bus_error_pin_oe == (bus_error_signal && !device_is_master) && !bus_error_pin_out;
  endproperty
  property p_err_hold;
    bus_error_signal && bus_cycle_active |=> bus_error_signal;
  endproperty
  property p_err_cause;
    $rose(bus_error_signal) |-> $past(bus_cycle_active);
  endproperty
  // Selected limit plus slack for the freeze synchroniser
  property p_bm_timeout;
    wait_cnt == (7'd64 >> prot[1:0]) + 7'd3 |-> bus_error_signal;
  endproperty
  property p_halt;
    cpu_halt && prot[3] |=> sys_reset_req;
  endproperty
  property p_denied;
    s_denied |-> pslverr && prdata == 32'h0;
  endproperty
  property p_pit_level;
    $rose(pit_irq_req) |-> pit_irq_level != 3'h0;
  endproperty
  property p_spur;
    s_spurious |=> bus_error_signal;
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("pin enable wrong");
  a_err_hold: assert property (p_err_hold) else $error("bus error dropped");
  a_err_cause: assert property (p_err_cause) else $error("bus error without cycle");
  a_bm_timeout: assert property (p_bm_timeout) else $error("monitor missed timeout");
  a_halt: assert property (p_halt) else $error("halt gave no reset");
  a_denied: assert property (p_denied) else $error("access not refused");
  a_pit_level: assert property (p_pit_level) else $error("request with level 0");
  a_spur: assert property (p_spur) else $error("spurious ack not ended");
endmodule
bind spm_top spm_top_asserts chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .function_code,
  .prdata, .pslverr, .freeze, .bus_cycle_active, .bus_cycle_external, .data_size_acknowledge, .device_is_master,
  .cpu_halt, .interrupt_acknowledge_cycle, .ack_arb_done, .ack_arb_seen, .bus_error_signal, .bus_error_pin_out,
  .bus_error_pin_oe, .sys_reset_req, .pit_irq_req, .pit_irq_level);

// File: testbench/spm_top_test.sv
// Self-checking bench for the protection monitors
`timescale 1ns/10ps
`include "spm_defs.vh"
`define CHK(nm, ex, got) \
  begin \
    check_count = check_count + 1; \
    if ((got) !== (ex)) \
    begin \
      fail_count = fail_count + 1; \
      $display("[ERR] %s exp %h got %h", nm, ex, got); \
    end \
  end
module spm_top_test;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [23:0] paddr = 24'h0;
  reg  [31:0] pwdata = 32'h0;
  reg  [2:0]  function_code = 3'h5;
  reg         freeze = 1'b0;
  reg         slave_strap_pin = 1'b1;
  reg         device_is_master = 1'b0;
  reg         cpu_halt = 1'b0;
  reg  [23:0] base = 24'hfffa00;
  reg  [31:0] rd;
  reg         err;
  integer     fail_count = 0;
  integer     check_count = 0;
  integer     cyc = 0;
  integer     pulses = 0;
  integer     n;
  integer     t;
  wire [31:0] prdata;
  wire [2:0]  ack_level, pit_irq_level;
  wire        pready, pslverr, bus_cycle_active, bus_cycle_external, data_size_acknowledge;
  wire        interrupt_acknowledge_cycle, ack_arb_done, ack_arb_seen, bus_error_signal;
  wire        bus_error_pin_out, bus_error_pin_oe, sys_reset_req, pit_irq_req;
  spm_top #(.REF_DIV(4)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .function_code,
    .prdata, .pready, .pslverr, .freeze, .slave_strap_pin, .bus_cycle_active, .bus_cycle_external,
    .data_size_acknowledge, .device_is_master, .cpu_halt, .interrupt_acknowledge_cycle, .ack_level,
    .ack_arb_done, .ack_arb_seen, .bus_error_signal, .bus_error_pin_out, .bus_error_pin_oe,
    .sys_reset_req, .pit_irq_req, .pit_irq_level);
  spm_core_model core (.pclk, .bus_error_signal, .bus_cycle_active, .bus_cycle_external,
    .data_size_acknowledge, .interrupt_acknowledge_cycle, .ack_level, .ack_arb_done, .ack_arb_seen);
  // 200 MHz clock
  initial
  begin
    forever #2.5 pclk = ~pclk;
  end
  // Cycle ceiling and reset request tally; nonblocking so readers see a settled count
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (sys_reset_req === 1'b1)
      pulses <= pulses + 1;
    if (cyc == 15000)
    begin
      fail_count = fail_count + 1;
      end_of_test;
    end
  end
  task end_of_test;
    begin
      if (fail_count == 0 && check_count > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // One APB transfer, held until pready is seen at an edge; an idle edge follows so no strobe is set twice
  task apb(input reg wr, input reg [7:0] idx, input reg [31:0] wd, input reg [2:0] sp);
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= base + {14'h0, idx, 2'b00};
      pwdata <= wd;
      function_code <= sp;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
        @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task rd_chk(input reg [7:0] idx, input reg [2:0] sp, input reg [31:0] ex, input reg ex_err, input string nm);
    begin
      apb(1'b0, idx, 32'h0, sp);
      `CHK(nm, ex, rd)
      `CHK(nm, ex_err, err)
    end
  endtask
  // Reset values, write-once map bit, strap bit and access spaces
  task t_regs;
    begin
      rd_chk(8'h00, 3'h5, 32'h68cf, 1'b0, "config");
      rd_chk(8'h20, 3'h5, 32'h08, 1'b0, "prot");
      apb(1'b1, 8'h00, 32'h600f, 3'h5);
      base = 24'h7ffa00;
      rd_chk(8'h00, 3'h5, 32'h680f, 1'b0, "config");
      base = 24'hfffa00;
      rd_chk(8'h00, 3'h5, 32'h0, 1'b1, "old base");
      base = 24'h7ffa00;
      apb(1'b1, 8'h00, 32'h604f, 3'h5);
      rd_chk(8'h00, 3'h5, 32'h680f, 1'b0, "map once");
      rd_chk(8'h28, 3'h1, 32'h0, 1'b0, "user open");
      rd_chk(8'h20, 3'h1, 32'h0, 1'b1, "prot user");
      apb(1'b1, 8'h00, 32'h608f, 3'h5);
      rd_chk(8'h28, 3'h1, 32'h0, 1'b1, "user shut");
      rd_chk(8'h28, 3'h4, 32'h0, 1'b0, "user fc2");
      rd_chk(8'h02, 3'h5, 32'h0, 1'b1, "unmapped");
    end
  endtask
  // Every response limit, prompt ack, external option and freeze
  task t_bm;
    begin
      for (n = 0; n < 4; n = n + 1)
      begin
        device_is_master <= n[0];
        apb(1'b1, 8'h20, n, 3'h5);
        core.xfer(-1, 120, 1'b0);
        `CHK("limit", 1'b1, core.err_at >= (64 >> n) - 1 && core.err_at <= (64 >> n) + 1)
        core.xfer(3, 120, 1'b0);
        `CHK("acked", -1, core.err_at)
      end
      core.xfer(-1, 30, 1'b1);
      `CHK("ext off", -1, core.err_at)
      apb(1'b1, 8'h20, 32'h07, 3'h5);
      core.xfer(-1, 30, 1'b1);
      `CHK("ext on", 1'b1, core.err_at >= 7 && core.err_at <= 9)
      freeze <= 1'b1;
      repeat (3) @(posedge pclk);
      core.xfer(-1, 30, 1'b0);
      `CHK("bm frozen", -1, core.err_at)
      freeze <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask
  // Halt gives reset only with the halt monitor on
  task t_halt;
    begin
      apb(1'b1, 8'h20, 32'h08, 3'h5);
      cpu_halt <= 1'b1;
      repeat (3) @(posedge pclk);
      `CHK("halt on", 1'b1, sys_reset_req)
      cpu_halt <= 1'b0;
      // Causes so far: halt and the monitor timeouts of the bus test
      rd_chk(8'h06, 3'h5, 32'h5, 1'b0, "cause");
      apb(1'b1, 8'h06, 32'h7, 3'h5);
      rd_chk(8'h06, 3'h5, 32'h0, 1'b0, "cause clr");
      apb(1'b1, 8'h20, 32'h00, 3'h5);
      cpu_halt <= 1'b1;
      repeat (3) @(posedge pclk);
      `CHK("halt off", 1'b0, sys_reset_req)
      cpu_halt <= 1'b0;
    end
  endtask
  // Periodic timer: frozen, running, own acknowledge, reload
  task t_pit;
    begin
      freeze <= 1'b1;
      apb(1'b1, 8'h22, 32'h3, 3'h5);
      apb(1'b1, 8'h24, 32'h002, 3'h5);
      repeat (200) @(posedge pclk);
      `CHK("pit frozen", 1'b0, pit_irq_req)
      freeze <= 1'b0;
      for (t = 0; t < 200 && pit_irq_req !== 1'b1; t = t + 1)
        @(posedge pclk);
      `CHK("pit req", 1'b1, pit_irq_req)
      `CHK("pit level", 3'h3, pit_irq_level)
      core.int_ack(3'h3, 1'b0);
      `CHK("own ack", -1, core.err_at)
      `CHK("req clear", 1'b0, pit_irq_req)
      for (t = 0; t < 200 && pit_irq_req !== 1'b1; t = t + 1)
        @(posedge pclk);
      `CHK("reload", 1'b1, pit_irq_req)
      apb(1'b1, 8'h24, 32'h0, 3'h5);
    end
  endtask
  // Watchdog: timely service keeps it quiet, then one full period to expiry
  task t_wd;
    begin
      apb(1'b1, 8'h20, 32'h80, 3'h5);
      n = pulses;
      for (t = 0; t < 4; t = t + 1)
      begin
        repeat (1500) @(posedge pclk);
        apb(1'b1, 8'h26, 32'h55, 3'h5);
        apb(1'b1, 8'h26, 32'haa, 3'h5);
      end
      `CHK("serviced", n, pulses)
      for (t = 0; t < 2200 && pulses == n; t = t + 1)
        @(posedge pclk);
      `CHK("expiry", 1'b1, t >= 2030 && t <= 2060)
    end
  endtask
  // Main sequence
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_regs;
    t_bm;
    t_halt;
    core.int_ack(3'h2, 1'b0);
    `CHK("spurious", 1'b1, core.err_at >= 0)
    core.int_ack(3'h2, 1'b1);
    `CHK("arbitrated", -1, core.err_at)
    t_pit;
    t_wd;
    end_of_test;
  end
endmodule

// File: verilog/spm_defs.vh
// Register map, field positions, reset values and timing counts of the protection monitors
`ifndef SPM_DEFS_VH
`define SPM_DEFS_VH

// Register indices; the APB byte address is base + 4 * index
`define SPM_IDX_MODCFG   8'h00
`define SPM_IDX_RSTSTAT  8'h06
`define SPM_IDX_PROT     8'h20
`define SPM_IDX_PITCTL   8'h22
`define SPM_IDX_PITTIM   8'h24
`define SPM_IDX_SERVICE  8'h26
`define SPM_IDX_USTAT    8'h28

// Register block base, low 20 bits; the top nibble is {map bit, 3'b111}
`define SPM_BASE_LOW     20'hffa00
`define SPM_SPACE_SUP    3'b101

// Module configuration register fields
`define SPM_CFG_CLKOFF   15
`define SPM_CFG_FRZ_TMR  14
`define SPM_CFG_FRZ_BM   13
`define SPM_CFG_SLAVE    11
`define SPM_CFG_SHOW_HI  9
`define SPM_CFG_SHOW_LO  8
`define SPM_CFG_SUP      7
`define SPM_CFG_MAP      6
`define SPM_CFG_ARB_HI   3
`define SPM_CFG_RST      16'h60cf
`define SPM_CFG_WMASK    16'he38f

// Protection control fields
`define SPM_PROT_WD_EN   7
`define SPM_PROT_WD_PRE  6
`define SPM_PROT_WD_SHI  5
`define SPM_PROT_WD_SLO  4
`define SPM_PROT_HALT_EN 3
`define SPM_PROT_BM_EXT  2
`define SPM_PROT_BM_SHI  1
`define SPM_PROT_BM_SLO  0
`define SPM_PROT_RST     8'h08

// Periodic timer fields
`define SPM_PIT_PRE      8
`define SPM_PITTIM_RST   9'h000
`define SPM_PITCTL_RST   3'h0

// Reset status bits
`define SPM_RS_HALT      0
`define SPM_RS_WD        1
`define SPM_RS_BUSERR    2

// Watchdog service keys
`define SPM_KEY_ARM      8'h55
`define SPM_KEY_FIRE     8'haa

// Timing: system clock, crystal reference and dividers
`define SPM_CLK_HZ       200000000
`define SPM_REF_HZ       32768
`define SPM_REF_DIV      (`SPM_CLK_HZ / `SPM_REF_HZ)
`define SPM_PIT_BASE_DIV 12'd4
`define SPM_PIT_PRE_DIV  12'd2048
`define SPM_WD_BASE_LOG2 9
`define SPM_WD_PRE_LOG2  9
`define SPM_BM_MAX       7'd64

`endif

// File: verilog/spm_div.v
// Programmable tick divider used by the protection monitors
`timescale 1ns/10ps
module spm_div #(
  parameter W = 16
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         run,
  input  wire         clear,
  input  wire [W-1:0] limit,
  output wire         tick
);
  reg [W-1:0] count;

  // One tick every limit qualified cycles; a limit of zero gives the longest period
  assign tick = run & ~clear & (count >= limit - {{(W-1){1'b0}}, 1'b1});

  // Count only qualified cycles so a paused divider keeps its phase
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count <= {W{1'b0}};
    else if (clear || tick)
      count <= {W{1'b0}};
    else if (run)
      count <= count + {{(W-1){1'b0}}, 1'b1};
  end
endmodule

// File: verilog/spm_top.v
// System protection monitors: bus monitor, halt, spurious interrupt, watchdog, periodic timer
//
// Contract
// - Bus error raised when acknowledge misses the selected response time.
// - Four software-selectable bus monitor response limits.
// - Option extends bus monitoring to internal-to-external accesses.
// - As bus master, monitor timeout drives bus error internally only.
// - Halt indication with halt monitor active generates system reset.
// - Interrupt acknowledge with no arbitration participant ends with bus error.
// - Software must service watchdog in time, else system reset.
// - Four watchdog periods, optional prescaler lengthens them.
// - Periodic timer period 122 us to 15.94 s from 32.768 kHz.
// - Register block top address nibble is map bit followed by 111.
// - Supervisor registers need function code 101; X01 ones follow supervisor bit.
// - Configuration register mixes writable controls and read-only status.
// - Supervisor bit set: governed registers need function code bit 2 high.
// - Freeze with timer-freeze enable stops watchdog and periodic timer.
// - Freeze with bus-monitor-freeze enable disables the bus monitor.
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "spm_defs.vh"
module spm_top #(
  parameter REF_DIV = `SPM_REF_DIV
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [23:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [2:0]  function_code,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        freeze,
  input  wire        slave_strap_pin,
  input  wire        bus_cycle_active,
  input  wire        bus_cycle_external,
  input  wire        data_size_acknowledge,
  input  wire        device_is_master,
  input  wire        cpu_halt,
  input  wire        interrupt_acknowledge_cycle,
  input  wire [2:0]  ack_level,
  input  wire        ack_arb_done,
  input  wire        ack_arb_seen,
  output reg         bus_error_signal,
  output wire        bus_error_pin_out,
  output wire        bus_error_pin_oe,
  output reg         sys_reset_req,
  output reg         pit_irq_req,
  output wire [2:0]  pit_irq_level
);
  // Registers and state
  reg  [15:0] module_config_register;
  reg         map_locked;
  reg  [7:0]  prot_ctrl;
  reg  [2:0]  pit_ctrl;
  reg  [8:0]  pit_timing;
  reg  [2:0]  reset_status;
  reg         service_armed;
  reg  [24:0] wd_cnt;
  reg  [7:0]  pit_cnt;
  reg  [6:0]  bm_cnt;
  reg         strap_s1;
  reg         strap_s2;
  reg         freeze_s1;
  reg         freeze_s2;
  reg  [1:0]  strap_wait;

  // Address decode and bus qualifiers
  wire [23:0] reg_base;
  wire [23:0] reg_off;
  wire [7:0]  idx;
  wire        in_range;
  wire        access_ok;
  wire        acc;
  wire        wr;
  wire        setup;
  wire        sup_bit;
  wire        timers_run;
  wire        bm_enable;
  wire        ref_tick;
  wire        pit_tick;
  wire        pit_on;
  wire        wd_service;
  wire        wd_expire;
  wire        pit_expire;
  wire        bm_watch;
  wire        bm_timeout;
  wire        own_arbitrates;
  wire        spurious;
  wire        halt_reset;
  reg  [31:0] next_prdata;

  // Known register indices
  function reg_known;
    input [7:0] i;
    begin
      reg_known = (i == `SPM_IDX_MODCFG) | (i == `SPM_IDX_RSTSTAT) | (i == `SPM_IDX_PROT) |
                  (i == `SPM_IDX_PITCTL) | (i == `SPM_IDX_PITTIM) | (i == `SPM_IDX_SERVICE) |
                  (i == `SPM_IDX_USTAT);
    end
  endfunction

  // Bus monitor limit in cycles: 64, 32, 16, 8
  function [6:0] bm_limit;
    input [1:0] sel;
    begin
      bm_limit = `SPM_BM_MAX >> sel;
    end
  endfunction

  // Watchdog period in reference ticks: 2^9..2^15, times 512 with prescaler
  function [24:0] wd_limit;
    input [1:0] sel;
    input       pre;
    reg   [4:0] sh;
    begin
      sh = 5'd`SPM_WD_BASE_LOG2 + {2'b00, sel, 1'b0} + (pre ? 5'd`SPM_WD_PRE_LOG2 : 5'd0);
      wd_limit = 25'd1 << sh;
    end
  endfunction

  // Register block sits at {map,111} in the top nibble
  assign reg_base = {module_config_register[`SPM_CFG_MAP], 3'b111, `SPM_BASE_LOW};
  assign reg_off  = paddr - reg_base;
  assign in_range = (reg_off[23:8] == 16'h0000) & (reg_off[1:0] == 2'b00);
  assign idx      = {2'b00, reg_off[7:2]};
  assign sup_bit  = module_config_register[`SPM_CFG_SUP];

  // Only the user status register follows the supervisor bit; the rest need 101
  assign access_ok = in_range & reg_known(idx) &
                     ((idx == `SPM_IDX_USTAT) ? (~sup_bit | function_code[2])
                                              : (function_code == `SPM_SPACE_SUP));
  assign setup   = psel & ~penable;
  assign acc     = psel & penable;
  assign wr      = acc & pwrite & access_ok;
  assign pready  = 1'b1;
  assign pslverr = acc & ~access_ok;

  // Pin inputs pass two flops before use
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_s1  <= 1'b0;
      strap_s2  <= 1'b0;
      freeze_s1 <= 1'b0;
      freeze_s2 <= 1'b0;
    end
    else
    begin
      strap_s1  <= slave_strap_pin;
      strap_s2  <= strap_s1;
      freeze_s1 <= freeze;
      freeze_s2 <= freeze_s1;
    end
  end

  assign timers_run = ~(freeze_s2 & module_config_register[`SPM_CFG_FRZ_TMR]);
  assign bm_enable  = ~(freeze_s2 & module_config_register[`SPM_CFG_FRZ_BM]);

  // Configuration register: writable controls, read-only slave strap, write-once map bit
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      module_config_register <= `SPM_CFG_RST;
      map_locked             <= 1'b0;
      strap_wait             <= 2'd0;
    end
    else
    begin
      if (strap_wait != 2'd3)
        strap_wait <= strap_wait + 2'd1;
      // Strap is caught once the synchroniser has settled after release
      if (strap_wait == 2'd2)
        module_config_register[`SPM_CFG_SLAVE] <= strap_s2;
      if (wr && idx == `SPM_IDX_MODCFG)
      begin
        module_config_register[15:13] <= pwdata[15:13];
        module_config_register[`SPM_CFG_SHOW_HI:`SPM_CFG_SHOW_LO] <= pwdata[9:8];
        module_config_register[`SPM_CFG_SUP] <= pwdata[`SPM_CFG_SUP];
        module_config_register[`SPM_CFG_ARB_HI:0] <= pwdata[3:0];
        if (!map_locked)
          module_config_register[`SPM_CFG_MAP] <= pwdata[`SPM_CFG_MAP];
        map_locked <= 1'b1;
      end
    end
  end

  // Protection and periodic timer control registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prot_ctrl  <= `SPM_PROT_RST;
      pit_ctrl   <= `SPM_PITCTL_RST;
      pit_timing <= `SPM_PITTIM_RST;
    end
    else if (wr)
    begin
      if (idx == `SPM_IDX_PROT)
        prot_ctrl <= pwdata[7:0];
      if (idx == `SPM_IDX_PITCTL)
        pit_ctrl <= pwdata[2:0];
      if (idx == `SPM_IDX_PITTIM)
        pit_timing <= pwdata[8:0];
    end
  end

  // Read data captured in the setup cycle so prdata comes from a flop
  always @*
  begin
    next_prdata = 32'h0000_0000;
    if (setup && !pwrite && access_ok)
    begin
      case (idx)
        `SPM_IDX_MODCFG:  next_prdata = {16'h0000, module_config_register};
        `SPM_IDX_RSTSTAT: next_prdata = {29'h0, reset_status};
        `SPM_IDX_PROT:    next_prdata = {24'h0, prot_ctrl};
        `SPM_IDX_PITCTL:  next_prdata = {29'h0, pit_ctrl};
        `SPM_IDX_PITTIM:  next_prdata = {23'h0, pit_timing};
        `SPM_IDX_USTAT:   next_prdata = {7'h0, pit_irq_req, pit_cnt, 16'h0000};
        default:          next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup)
      prdata <= next_prdata;
  end

  // Crystal-rate reference tick
  spm_div #(.W(16)) u_ref_div (
    .clk   (pclk),
    .rst_n (presetn),
    .run   (1'b1),
    .clear (1'b0),
    .limit (REF_DIV[15:0]),
    .tick  (ref_tick)
  );

  // Watchdog: 55 arms, aa services; any other service write disarms
  assign wd_service = wr & (idx == `SPM_IDX_SERVICE) & service_armed & (pwdata[7:0] == `SPM_KEY_FIRE);
  assign wd_expire  = prot_ctrl[`SPM_PROT_WD_EN] & timers_run & ref_tick &
                      (wd_cnt >= wd_limit(prot_ctrl[5:4], prot_ctrl[`SPM_PROT_WD_PRE]) - 25'd1);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wd_cnt        <= 25'd0;
      service_armed <= 1'b0;
    end
    else
    begin
      if (wr && idx == `SPM_IDX_SERVICE)
        service_armed <= (pwdata[7:0] == `SPM_KEY_ARM);
      if (wd_service || wd_expire || !prot_ctrl[`SPM_PROT_WD_EN])
        wd_cnt <= 25'd0;
      else if (ref_tick && timers_run)
        wd_cnt <= wd_cnt + 25'd1;
    end
  end

  // Periodic timer: reference divided by 4, or by 2048 with prescaler
  assign pit_on = (pit_timing[7:0] != 8'h00);
  spm_div #(.W(12)) u_pit_div (
    .clk   (pclk),
    .rst_n (presetn),
    .run   (ref_tick & timers_run & pit_on),
    .clear (~pit_on),
    .limit (pit_timing[`SPM_PIT_PRE] ? `SPM_PIT_PRE_DIV : `SPM_PIT_BASE_DIV),
    .tick  (pit_tick)
  );
  assign pit_expire = pit_tick & (pit_cnt <= 8'd1);

  // Count down from the modulus and reload on expiry
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pit_cnt <= 8'h00;
    else if (!pit_on)
      pit_cnt <= 8'h00;
    else if (pit_expire || pit_cnt == 8'h00)
      pit_cnt <= pit_timing[7:0];
    else if (pit_tick)
      pit_cnt <= pit_cnt - 8'd1;
  end

  // Interrupt request held until this block wins an acknowledge; new expiry wins over clear
  assign pit_irq_level  = pit_ctrl;
  assign own_arbitrates = pit_irq_req & (module_config_register[3:0] != 4'h0) & (ack_level == pit_ctrl);
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pit_irq_req <= 1'b0;
    else if (pit_expire && pit_ctrl != 3'h0)
      pit_irq_req <= 1'b1;
    else if (interrupt_acknowledge_cycle && ack_arb_done && own_arbitrates)
      pit_irq_req <= 1'b0;
  end

  // Bus monitor counts cycles of a watched transfer until acknowledge
  assign bm_watch   = bus_cycle_active & bm_enable &
                      (~bus_cycle_external | prot_ctrl[`SPM_PROT_BM_EXT]);
  assign bm_timeout = bm_watch & ~data_size_acknowledge &
                      (bm_cnt == bm_limit(prot_ctrl[1:0]) - 7'd1);
  assign spurious   = interrupt_acknowledge_cycle & ack_arb_done & ~ack_arb_seen & ~own_arbitrates;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bm_cnt <= 7'd0;
    else if (!bm_watch || data_size_acknowledge)
      bm_cnt <= 7'd0;
    else if (bm_cnt != `SPM_BM_MAX)
      bm_cnt <= bm_cnt + 7'd1;
  end

  // Bus error holds until the transfer ends
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bus_error_signal <= 1'b0;
    else if (bm_timeout || spurious)
      bus_error_signal <= 1'b1;
    else if (!bus_cycle_active)
      bus_error_signal <= 1'b0;
  end

  // Pin is driven low only when an external master owns the bus
  assign bus_error_pin_out = 1'b0;
  assign bus_error_pin_oe  = bus_error_signal & ~device_is_master;

  // System reset request and its cause; causes are write-one-to-clear, set wins
  assign halt_reset = cpu_halt & prot_ctrl[`SPM_PROT_HALT_EN];
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sys_reset_req <= 1'b0;
      reset_status  <= 3'b000;
    end
    else
    begin
      sys_reset_req <= halt_reset | wd_expire;
      reset_status[`SPM_RS_HALT] <= halt_reset |
        (reset_status[`SPM_RS_HALT] & ~(wr & (idx == `SPM_IDX_RSTSTAT) & pwdata[`SPM_RS_HALT]));
      reset_status[`SPM_RS_WD] <= wd_expire |
        (reset_status[`SPM_RS_WD] & ~(wr & (idx == `SPM_IDX_RSTSTAT) & pwdata[`SPM_RS_WD]));
      reset_status[`SPM_RS_BUSERR] <= bm_timeout |
        (reset_status[`SPM_RS_BUSERR] & ~(wr & (idx == `SPM_IDX_RSTSTAT) & pwdata[`SPM_RS_BUSERR]));
    end
  end
endmodule
